//--- design/bpbm_pkg.sv
// Purpose: Shared constants and types of the block protection bit map.
// Assumes: Locations are 10-bit values wide enough for 2^8 + 1 + 14.
// Notes:   Register offsets are byte addresses on a 32-bit APB port.
package bpbm_pkg;
    localparam int unsigned ADDR_W   = 24;     // Flash byte address width.
    localparam int unsigned LOC_W    = 10;     // Protection bit location width.
    localparam int unsigned NUM_SECT = 5;      // Major sections, bottom to top.
    localparam int unsigned NUM_FLD  = 2;      // Start and end fields.
    localparam logic [3:0]  DENS_MIN = 4'h4;   // Density constant for 8 Mbit.
    localparam logic [3:0]  DENS_MAX = 4'h8;   // Density constant for 128 Mbit.
    localparam logic [3:0]  DENS_RST = 4'h5;   // Density after reset.
    // Register byte offsets.
    localparam logic [7:0]  OFF_CFG    = 8'h00;
    localparam logic [7:0]  OFF_QUERY  = 8'h04;
    localparam logic [7:0]  OFF_RESULT = 8'h08;
    localparam logic [7:0]  OFF_SECT0  = 8'h10;
    // Result word field positions.
    localparam int unsigned RES_READ_LSB = 16;
    localparam int unsigned RES_SEC_LSB  = 26;
    localparam int unsigned RES_PAIR     = 29;
    localparam int unsigned RES_FAULT    = 30;
    // Section indices in address order.
    localparam logic [2:0]  SEC_BOT8   = 3'h0;
    localparam logic [2:0]  SEC_LOW32  = 3'h1;
    localparam logic [2:0]  SEC_MAIN64 = 3'h2;
    localparam logic [2:0]  SEC_UP32   = 3'h3;
    localparam logic [2:0]  SEC_TOP8   = 3'h4;
    // Address bit positions of the block layout.
    localparam int unsigned BLK64_LSB = 16;
    localparam int unsigned HALF_BIT  = 15;
    localparam int unsigned BLK8_LSB  = 13;
    // Field value meaning absolute bit zero instead of an adder.
    localparam logic [7:0]  ABS_ZERO = 8'h00;
    // Per-section type, count exponent, start adder and end adder.
    localparam logic [7:0] SECT_TYPE [NUM_SECT] = '{8'h02, 8'h03, 8'h04, 8'h03, 8'h02};
    localparam logic [7:0] SECT_CNT  [NUM_SECT] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h02};
    localparam logic [7:0] SECT_BEG  [NUM_SECT] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
    localparam logic [7:0] SECT_END  [NUM_SECT] = '{8'h04, 8'hfd, 8'hfc, 8'hfe, 8'h0e};
    // Parameter-table locations of the sector type size entries.
    localparam logic [7:0] TYPE_LOC  [NUM_SECT] = '{8'h4e, 8'h50, 8'h52, 8'h50, 8'h4e};

    typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_ACK = 2'b01} bpbm_apb_e;

    typedef struct packed {
        bpbm_apb_e          apb;      // Bus slave phase.
        logic               pready;   // Access answer.
        logic               pslverr;  // Access error.
        logic [31:0]        prdata;   // Read data.
        logic [3:0]         dens;     // Density constant m.
        logic [ADDR_W-1:0]  addr;     // Queried flash address.
        logic [LOC_W-1:0]   bit_loc;  // Governing bit, write lock for 8K.
        logic [LOC_W-1:0]   read_loc; // Read lock bit for 8K blocks.
        logic [2:0]         sect;     // Section of the address.
        logic               pair;     // Read and write pair is valid.
        logic               fault;    // Address or bit outside the map.
    } bpbm_state_s;

    localparam bpbm_state_s ST_RESET = '{apb: APB_IDLE, pready: 1'b0, pslverr: 1'b0,
        prdata: 32'h0000_0000, dens: DENS_RST, addr: 24'h00_0000, bit_loc: 10'h000,
        read_loc: 10'h000, sect: SEC_BOT8, pair: 1'b0, fault: 1'b0};
endpackage

//--- design/bpbm_map_if.sv
// Purpose: Carries the query between the top and its two decoders.
// Assumes: Purely combinational signals on one clock.
// Notes:   The owner drives density, address and the section fields.
interface bpbm_map_if;
    import bpbm_pkg::*;
    logic [3:0]        dens;            // Density constant m.
    logic [ADDR_W-1:0] addr;            // Flash byte address.
    logic [2:0]        sect;            // Section holding the address.
    logic [7:0]        blk;             // Block index inside the section.
    logic              beyond;          // Address above the density.
    logic [7:0]        field [NUM_FLD]; // Start and end adder fields.
    logic [LOC_W-1:0]  loc   [NUM_FLD]; // Decoded bit locations.
    modport classify (input dens, addr, output sect, blk, beyond);
    modport decode   (input dens, field, output loc);
endinterface

//--- design/bpbm_addr_classify.sv
// Purpose: Finds the section and block index that hold an address.
// Assumes: Density constant between four and eight.
// Notes:   The first and last 64-Kbyte slots hold the small blocks.
module bpbm_addr_classify
    import bpbm_pkg::*;
(
    bpbm_map_if.classify mp
);
    logic [7:0] mask;  // Ones across the 64-Kbyte index bits.
    logic [7:0] blk64; // 64-Kbyte slot of the address.

    // The lowest slot splits into 8K blocks then 32K; the top one mirrors it.
    // slot layout by address
    always_comb
    begin
        mask      = 8'((9'h001 << mp.dens) - 9'h001);
        blk64     = mp.addr[ADDR_W-1:BLK64_LSB] & mask;
        mp.beyond = (mp.addr[ADDR_W-1:BLK64_LSB] & ~mask) != 8'h00;
        if (blk64 == 8'h00)
        begin
            mp.sect = mp.addr[HALF_BIT] ? SEC_LOW32 : SEC_BOT8;
            mp.blk  = mp.addr[HALF_BIT] ? 8'h00 : {6'h00, mp.addr[HALF_BIT-1:BLK8_LSB]};
        end
        else if (blk64 == mask)
        begin
            mp.sect = mp.addr[HALF_BIT] ? SEC_TOP8 : SEC_UP32;
            mp.blk  = mp.addr[HALF_BIT] ? {6'h00, mp.addr[HALF_BIT-1:BLK8_LSB]} : 8'h00;
        end
        else
        begin
            mp.sect = SEC_MAIN64;
            mp.blk  = blk64 - 8'h01;
        end
    end
endmodule

//--- design/bpbm_adder_decode.sv
// Purpose: Turns stored start and end fields into bit locations.
// Assumes: Fields are two's complement adders on 2^m + 1.
// Notes:   A zero field is the absolute location zero.
module bpbm_adder_decode
    import bpbm_pkg::*;
(
    bpbm_map_if.decode mp
);
    for (genvar i = 0; i < NUM_FLD; i++)
    begin : g_fld
        // Sign-extend the adder so that negative values subtract.
        // base plus adder
        assign mp.loc[i] = (mp.field[i] == ABS_ZERO) ? '0
            : LOC_W'((LOC_W'(1) << mp.dens) + LOC_W'(1) + LOC_W'($signed(mp.field[i])));
    end
endmodule

//--- design/bpbm_top.sv
// Purpose: Maps a flash address to its block protection register bits.
// Assumes: APB master on sys_clk; synchronous active-high reset.
// Notes:   Results are registered one clock after the query changes.
//
// How it works
// - Layout: 4x8K, 32K, 64K run, 32K, 4x8K.
// - 8K blocks are sector type two.
// - 32K blocks are sector type three.
// - 64K blocks are sector type four.
// - Small section count is two to n.
// - 64K block count is 2^m minus two.
// - Density constant m spans four to eight.
// - Location is 2^m plus one plus adder.
// - Adder is signed; zero means bit zero.
// - Bottom 8K adders are -1 and 4.
// - 32K sections use -3 and -2.
// - 64K run starts at zero, ends -4.
// - Top 8K adders are 7 and 14.
// - 8K bits: odd read lock, even write.
// - 64K bits step by one per block; 8K pairs step by two.
//
// The register addresses and the APB register port were decided locally.
module bpbm_top
    import bpbm_pkg::*;
(
    input  wire logic              sys_clk,       // System clock, 40 MHz.
    input  wire logic              rst,           // Synchronous reset.
    input  wire logic              psel,          // APB select.
    input  wire logic              penable,       // APB access phase.
    input  wire logic              pwrite,        // APB direction.
    input  wire logic [7:0]        paddr,         // APB byte address.
    input  wire logic [31:0]       pwdata,        // APB write data.
    output logic      [31:0]       prdata,        // APB read data.
    output logic                   pready,        // APB answer.
    output logic                   pslverr,       // APB error.
    output logic      [LOC_W-1:0]  prot_bit,      // Governing bit location.
    output logic      [LOC_W-1:0]  read_lock_bit, // Read lock for 8K blocks.
    output logic                   lock_pair,     // Read and write pair valid.
    output logic      [2:0]        prot_section,  // Section of the query.
    output logic                   map_fault      // Query outside the map.
);
    ////////////////////////////////////////////////////////////////////////////
    // State and the decoders.
    ////////////////////////////////////////////////////////////////////////////

    bpbm_state_s       st_q;     // All registered state.
    bpbm_state_s       st_d;     // Next value of the state.
    bpbm_map_if        u_map (); // Shared query signals.
    logic              is_small; // The section is an 8K section.
    logic [LOC_W-1:0]  bit_c;    // Governing bit of the current query.
    logic [LOC_W-1:0]  read_c;   // Read lock bit of the current query.
    logic              fault_c;  // Current query falls outside the map.
    logic [31:0]       res_word; // Result register as read now.
    logic [31:0]       rd_word;  // Word selected by the address.
    logic              rd_err;   // The address answers with an error.
    logic [2:0]        sel_sect; // Section picked by a descriptor read.
    logic [7:0]        sel_off;  // Offset from the first descriptor word.

    bpbm_addr_classify u_cls
    (
        .mp (u_map)
    );

    bpbm_adder_decode u_dec
    (
        .mp (u_map)
    );

    // The decoders always see the registered query, so reads and results agree.
    assign u_map.dens     = st_q.dens;
    assign u_map.addr     = st_q.addr;
    // A query write thus reaches the ports two edges after its access.
    // The table lookup is indexed by the live section of the query.
    // Adders of the section that holds the address.
    // start and end adders of any section
    assign u_map.field[0] = SECT_BEG[u_map.sect];
    assign u_map.field[1] = SECT_END[u_map.sect];

    ////////////////////////////////////////////////////////////////////////////
    // Address to protection bit mapping.
    ////////////////////////////////////////////////////////////////////////////

    // The 8K sections hold a write and read bit per block, so they step by two.
    // The bottom 8K range is only six bits wide, so its fourth block overruns;
    // that case raises the fault flag instead of silently wrapping.
    // On a fault the bit fields still show, and software must ignore them.
    always_comb
    begin
        is_small = (u_map.sect == SEC_BOT8) || (u_map.sect == SEC_TOP8);
        if (is_small)
        begin
            bit_c  = LOC_W'(u_map.loc[0] + LOC_W'({u_map.blk, 1'b0}));
            read_c = LOC_W'(bit_c + LOC_W'(1));
        end
        else
        begin
            bit_c  = LOC_W'(u_map.loc[0] + LOC_W'(u_map.blk));
            read_c = '0;
        end
        fault_c = u_map.beyond || (is_small ? (read_c > u_map.loc[1])
                                            : (bit_c > u_map.loc[1]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read data.
    ////////////////////////////////////////////////////////////////////////////

    // Result and descriptor words are built from live values, so a read right
    // after a query write already shows the new answer.
    // Writes to the result or descriptor words are refused with an error.
    always_comb
    begin
        res_word = 32'h0000_0000;
        res_word[LOC_W-1:0] = bit_c;
        res_word[RES_READ_LSB +: LOC_W] = read_c;
        res_word[RES_SEC_LSB +: 3] = u_map.sect;
        res_word[RES_PAIR] = is_small;
        res_word[RES_FAULT] = fault_c;
        // Descriptors are indexed from their own base, not from offset zero.
        sel_off = paddr - OFF_SECT0;
        sel_sect = sel_off[4:2];
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'b00)
        begin
            // Misaligned accesses are refused.
            rd_err = 1'b1;
        end
        else if (paddr == OFF_CFG)
        begin
            rd_word[3:0] = st_q.dens;
        end
        else if (paddr == OFF_QUERY)
        begin
            rd_word[ADDR_W-1:0] = st_q.addr;
        end
        else if (paddr == OFF_RESULT)
        begin
            rd_word = res_word;
        end
        else if ((paddr >= OFF_SECT0) && (sel_sect < 3'(NUM_SECT)) && (sel_off[7:5] == 3'h0))
        begin
            // Descriptor: type, count, start adder, end adder, low byte first.
            // type of the selected section
            rd_word[7:0] = SECT_TYPE[sel_sect];
            rd_word[15:8] = (sel_sect == SEC_MAIN64) ? {4'h0, st_q.dens} : SECT_CNT[sel_sect];
            rd_word[23:16] = SECT_BEG[sel_sect];
            rd_word[31:24] = SECT_END[sel_sect];
        end
        else
        begin
            // Unmapped offsets read zero with an error.
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state: APB slave and the result registers.
    ////////////////////////////////////////////////////////////////////////////

    // Zero wait states: the setup cycle loads the answer, and pready stands for
    // exactly the one access cycle.
    // A master that waits on pready and one that assumes no wait both work.
    always_comb
    begin
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.bit_loc = bit_c;
        st_d.read_loc = read_c;
        st_d.sect = u_map.sect;
        st_d.pair = is_small;
        st_d.fault = fault_c;
        unique case (st_q.apb)
            APB_IDLE:
            begin
                // A setup cycle prepares the answer for the access cycle.
                // Write data is taken later, at the access edge itself.
                if (psel && !penable)
                begin
                    st_d.apb = APB_ACK;
                    st_d.pready = 1'b1;
                    st_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
                    st_d.pslverr = pwrite ? !((paddr == OFF_CFG) || (paddr == OFF_QUERY))
                                          : rd_err;
                end
            end
            APB_ACK:
            begin
                // The write takes effect at the edge where pready is high.
                // The next setup can only follow this edge, so none is lost.
                st_d.apb = APB_IDLE;
                st_d.prdata = 32'h0000_0000;
                if (psel && penable && pwrite)
                begin
                    if ((paddr == OFF_CFG) && (pwdata[3:0] >= DENS_MIN)
                        && (pwdata[3:0] <= DENS_MAX) && (pwdata[31:4] == 28'h000_0000))
                    begin
                        st_d.dens = pwdata[3:0];
                    end
                    if (paddr == OFF_QUERY)
                    begin
                        st_d.addr = pwdata[ADDR_W-1:0];
                    end
                end
            end
        endcase
    end

    // One register for all state.
    // The reset is synchronous, so every field returns to it together.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= ST_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Every output is a flip-flop of the state.
    // No output is decoded after the register, so none can glitch.
    assign prdata        = st_q.prdata;
    assign pready        = st_q.pready;
    assign pslverr       = st_q.pslverr;
    assign prot_bit      = st_q.bit_loc;
    assign read_lock_bit = st_q.read_loc;
    assign lock_pair     = st_q.pair;
    assign prot_section  = st_q.sect;
    assign map_fault     = st_q.fault;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////

    logic [ADDR_W-1:0] top_addr; // Last byte of the array at this density.

    assign top_addr = ADDR_W'((25'h000_0001 << (BLK64_LSB + st_q.dens)) - 25'h000_0001);

    // Each property but a_pair_parity and a_read_zero looks one edge after the query it describes, so the
    // density in its expected value is taken from the cycle of that query.

    // A query that lands inside the 64K run of the present density.
    sequence s_main_hit;
        !rst && (u_map.sect == SEC_MAIN64) && !u_map.beyond;
    endsequence

    a_bottom_layout: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr < 24'h00_8000) |=> (st_q.sect == SEC_BOT8))
        else $error("low address not in bottom 8K section");

    a_top_block_end: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr) |=> (st_q.sect == SEC_TOP8 && !st_q.fault))
        else $error("last address not in top 8K section");

    a_bot8_start_loc: assert property (
        @(posedge sys_clk) disable iff (rst)
        !rst && (st_q.addr[ADDR_W-1:BLK8_LSB] == 11'h000)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens))))
        else $error("bottom 8K start location wrong");

    a_bot8_end_loc: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr[ADDR_W-1:BLK8_LSB] == 11'h002)
        |=> (st_q.read_loc == (10'(1) << $past(st_q.dens)) + 10'h005 && !st_q.fault))
        else $error("bottom 8K end location wrong");

    a_low32_loc: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr[ADDR_W-1:HALF_BIT] == 9'h001)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens)) - 10'h002))
        else $error("lower 32K location wrong");

    a_main64_start: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr[ADDR_W-1:BLK64_LSB] == 8'h01) |=> (st_q.bit_loc == 10'h000))
        else $error("first 64K block not at bit zero");

    a_top8_start: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr - 24'h00_7fff)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens)) + 10'h008 && st_q.pair))
        else $error("top 8K start location wrong");

    a_pair_parity: assert property (
        @(posedge sys_clk) disable iff (rst)
        st_q.pair |-> (!st_q.bit_loc[0] && st_q.read_loc == st_q.bit_loc + 10'h001))
        else $error("8K read and write bits misplaced");

    a_main64_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_main_hit |=> (st_q.bit_loc == LOC_W'($past(st_q.addr[ADDR_W-1:BLK64_LSB])) - 10'h001))
        else $error("64K bits do not step by one");

    a_up32_loc: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr - 24'h00_ffff)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens)) - 10'h001))
        else $error("upper 32K location wrong");

    a_main64_end: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr - 24'h01_0000)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens)) - 10'h003 && !st_q.fault))
        else $error("last 64K block location wrong");

    a_top8_end: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr)
        |=> (st_q.read_loc == (10'(1) << $past(st_q.dens)) + 10'h00f))
        else $error("top 8K end location wrong");

    a_top8_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr == top_addr - 24'h00_5fff)
        |=> (st_q.bit_loc == (10'(1) << $past(st_q.dens)) + 10'h00a))
        else $error("top 8K bits do not step");

    a_beyond_fault: assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.addr > top_addr) |=> st_q.fault)
        else $error("address above the array not flagged");

    a_read_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        !st_q.pair |-> (st_q.read_loc == 10'h000))
        else $error("read lock bit outside 8K sections");
endmodule

//--- bench/bpbm_host_model.sv
// Purpose: Host on the far side that reaches the map over APB.
// Assumes: Zero or more wait states; the slave answers with pready.
// Notes:   After time zero, signals change only by non-blocking assignment after a rising edge.
module bpbm_host_model
(
    input  wire logic        sys_clk, // System clock.
    input  wire logic        rst,     // Synchronous reset.
    output logic             psel,    // APB select.
    output logic             penable, // APB access phase.
    output logic             pwrite,  // APB direction.
    output logic [7:0]       paddr,   // APB byte address.
    output logic [31:0]      pwdata,  // APB write data.
    input  wire logic [31:0] prdata,  // APB read data.
    input  wire logic        pready,  // APB answer.
    input  wire logic        pslverr  // APB error.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus idles from time zero so no request precedes reset release.
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One whole transfer. The request holds until pready is seen high; the
    // wait is open ended because only the bench watchdog may end it.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        // Requests wait for reset to end so none is lost.
        do
            @(posedge sys_clk);
        while (rst !== 1'b0);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- bench/bpbm_top_test.sv
// Purpose: Self-checking bench of the protection bit map.
// Assumes: Host model drives APB; mapping outputs settle two edges after a write.
// Notes:   Corner addresses and seeded random addresses per density.
module bpbm_top_test;
    import bpbm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk = 1'b0; // 40 MHz clock.
    logic              rst     = 1'b1; // Held for ten cycles.
    logic              psel, penable, pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, lock_pair, map_fault;
    logic [LOC_W-1:0]  prot_bit, read_lock_bit;
    logic [2:0]        prot_section;
    int                fails      = 0; // Mismatches seen.
    int                num_checks = 0; // Comparisons made.
    int                seed       = 62737;
    logic [31:0]       rd;
    logic              er;

    always #12.5 sys_clk = ~sys_clk;

    bpbm_host_model host (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    bpbm_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prot_bit(prot_bit),
        .read_lock_bit(read_lock_bit), .lock_pair(lock_pair),
        .prot_section(prot_section), .map_fault(map_fault));

    ////////////////////////////////////////////////////////////////////////////
    // Prints the verdict; the only place the run ends.
    task automatic finish_test();
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Compares one value with its expectation and counts the outcome.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected result word; on a fault only the fault bit is meaningful.
    function automatic logic [31:0] exp_res(input int m, input logic [23:0] a);
        int p, slot, k;
        logic [31:0] r;
        p    = 1 << m;
        slot = int'(a[23:16]);
        k    = int'(a[14:13]);
        r    = 32'h0000_0000;
        if (slot >= p)
            r[30] = 1'b1;
        else if (slot == 0 && a[15] == 1'b0)
        begin
            // The fourth bottom block lands past the six-bit range.
            if (k == 3)
                r[30] = 1'b1;
            else
                r = {3'h1, SEC_BOT8, 10'(p + 2 * k + 1), 6'h00, 10'(p + 2 * k)};
        end
        else if (slot == 0)
            r = {3'h0, SEC_LOW32, 16'h0000, 10'(p - 2)};
        else if (slot == p - 1 && a[15] == 1'b0)
            r = {3'h0, SEC_UP32, 16'h0000, 10'(p - 1)};
        else if (slot == p - 1)
            r = {3'h1, SEC_TOP8, 10'(p + 9 + 2 * k), 6'h00, 10'(p + 8 + 2 * k)};
        else
            r = {3'h0, SEC_MAIN64, 16'h0000, 10'(slot - 1)};
        return r;
    endfunction

    // Expected descriptor word: end field, start field, count, type.
    function automatic logic [31:0] exp_desc(input int s, input int m);
        logic [31:0] t [5];
        t = '{32'h04ff_0202, 32'hfdfd_0003, {16'hfc00, 8'(m), 8'h04}, 32'hfefe_0003,
              32'h0e07_0202};
        return t[s];
    endfunction

    // Queries one address and checks the ports and the result register.
    task automatic query(input int m, input logic [23:0] a);
        logic [31:0] e, mk, pw;
        e  = exp_res(m, a);
        mk = (e[30] == 1'b1) ? 32'h4000_0000 : 32'hffff_ffff;
        host.xfer(1'b1, OFF_QUERY, {8'h00, a}, rd, er);
        repeat (2) @(posedge sys_clk);
        pw = {1'b0, map_fault, lock_pair, prot_section, read_lock_bit, 6'h00, prot_bit};
        check("ports", pw & mk, e & mk);
        // write lock bits are even in the small sections
        if (e[29] == 1'b1)
            check("write lock parity", {31'h0, prot_bit[0]}, 32'h0);
        host.xfer(1'b0, OFF_RESULT, 32'h0, rd, er);
        check("result", rd & mk, e & mk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("reset ports", {6'h00, prot_bit, read_lock_bit, 4'(prot_section), 2'(lock_pair)},
              {6'h00, 10'd32, 10'd33, 4'h0, 2'h1});
        host.xfer(1'b0, OFF_CFG, 32'h0, rd, er);
        check("reset density", rd, 32'h0000_0005);
        for (int m = 4; m <= 8; m++)
        begin
            host.xfer(1'b1, OFF_CFG, 32'(m), rd, er);
            for (int s = 0; s < 5; s++)
            begin
                host.xfer(1'b0, 8'(OFF_SECT0 + 4 * s), 32'h0, rd, er);
                check("descriptor", rd, exp_desc(s, m));
            end
            for (int k = 0; k < 4; k++)
                query(m, 24'(k * 32'h2000));
            query(m, 24'h00_8000);
            query(m, 24'h01_0000);
            query(m, 24'(((1 << m) - 2) * 32'h1_0000 + 32'hffff));
            for (int k = 0; k < 8; k++)
                query(m, 24'(((1 << m) - 1) * 32'h1_0000 + k * 32'h2000));
            if (m < 8)
                query(m, 24'((1 << m) * 32'h1_0000));
            for (int i = 0; i < 12; i++)
                query(m, 24'($random(seed) & ((1 << (m + 17)) - 1)));
        end
        // Refused accesses and ignored density values.
        host.xfer(1'b0, 8'h0c, 32'h0, rd, er);
        check("unmapped error", {31'h0, er}, 32'h1);
        host.xfer(1'b0, 8'h02, 32'h0, rd, er);
        check("misaligned error", {31'h0, er}, 32'h1);
        host.xfer(1'b1, OFF_RESULT, 32'h0, rd, er);
        check("read only error", {31'h0, er}, 32'h1);
        host.xfer(1'b1, OFF_CFG, 32'h9, rd, er);
        check("bad density no error", {31'h0, er}, 32'h0);
        host.xfer(1'b1, OFF_CFG, 32'h3, rd, er);
        host.xfer(1'b0, OFF_CFG, 32'h0, rd, er);
        check("density kept", rd, 32'h0000_0008);
        finish_test();
    end

    // A hang is cut short well beyond the expected run length.
    initial
    begin
        #(25 * 30000);
        fails++;
        finish_test();
    end
endmodule
